// >>> rtl/switch_cfg_pkg.sv
// Constants for the switch input configuration block
// What this block does
// - Every switch input has its own 20 ms wetting timer.
// - An input's timer starts when its comparator sees the 4.0 V crossing.
// - On expiry of an enabled timer, current drops from 16 mA to 2 mA.
// - With its timer disabled, an input keeps 16 mA continuously.
// - Timer enable bit 0 disables that input's timer, 1 enables it.
// - Code 07h writes programmable timer enables, 08h writes ground timer enables.
// - High impedance bit 1 floats the input regardless of metallic setting.
// - A floated input keeps its comparator working at 4.0 V.
// - Code 09h writes programmable floats, 0Ah writes ground floats.
// - Channel field decodes 0 none, 1-14 ground, 15-22 programmable inputs.
// - The selected analog input reads 0 in the next status response.
// - Current field: 00 high impedance, 01 2 mA, 10 16 mA.
// - Current field 11 is illegal and acts as high impedance.
// - Analog select currents are always pull-up, never pull-down.
// - Code 06h is analog select; bits 15 to 7 are ignored.
// - New settings are accepted at any time in normal mode while the logic supply is present.
// - Programming is accepted only in normal mode with logic supply present.
// - Reset: timers enabled, all inputs floated, channel cleared to zero.
package switch_cfg_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PROG   = 8;
    localparam int NUM_GND    = 14;
    localparam int NUM_INPUTS = 22;
    localparam int FRAME_BITS = 24;

    // ------------------------------------------------------------
    // Command codes in frame bits 23..16
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_ANALOG     = 8'h06;
    localparam logic [7:0] CMD_TIMER_PROG = 8'h07;
    localparam logic [7:0] CMD_TIMER_GND  = 8'h08;
    localparam logic [7:0] CMD_HIZ_PROG   = 8'h09;
    localparam logic [7:0] CMD_HIZ_GND    = 8'h0a;
    localparam logic [7:0] CMD_RESET      = 8'h7f;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CMD_MSB   = 23;
    localparam int CMD_LSB   = 16;
    localparam int CUR_MSB   = 6;
    localparam int CUR_LSB   = 5;
    localparam int CHAN_MSB  = 4;
    localparam int CHAN_LSB  = 0;

    // ------------------------------------------------------------
    // Channel map
    // ------------------------------------------------------------
    localparam logic [4:0] CHAN_NONE     = 5'h00;
    localparam logic [4:0] CHAN_GND_BASE = 5'h01;
    localparam logic [4:0] CHAN_PROG_BASE = 5'h0f;
    localparam logic [4:0] CHAN_LAST     = 5'h16;

    // ------------------------------------------------------------
    // Current select encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CUR_HIZ   = 2'h0;
    localparam logic [1:0] CUR_LOW   = 2'h1;
    localparam logic [1:0] CUR_HIGH  = 2'h2;
    localparam logic [1:0] CUR_ILLEG = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [21:0] RST_TIMER_EN = 22'h3fffff;
    localparam logic [21:0] RST_HIZ      = 22'h3fffff;
    localparam logic [6:0]  RST_ANALOG   = 7'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 50_000_000;
    localparam int WET_TIME_MS = 20;
    localparam int WET_CYCLES  = WET_TIME_MS * (CLK_HZ / 1000);

endpackage : switch_cfg_pkg

// >>> rtl/switch_input_config_regs.sv
// Serial configuration registers and wetting timers of the switch detector
module switch_input_config_regs
    import switch_cfg_pkg::*;
#(
    parameter int WET_COUNT = WET_CYCLES
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    // Operating conditions
    input  wire logic                  normal_mode,
    input  wire logic                  logic_supply_ok,
    // Serial port pins from the host
    input  wire logic                  spi_sclk,
    input  wire logic                  spi_cs_n,
    input  wire logic                  spi_mosi,
    // Comparator outputs, ground inputs low, programmable high
    input  wire logic [NUM_INPUTS-1:0] input_above_thresh,
    // Raw switch status from the comparators
    input  wire logic [NUM_INPUTS-1:0] switch_closed,
    // Per-input current drive
    output logic      [NUM_INPUTS-1:0] input_hiz,
    output logic      [NUM_INPUTS-1:0] wetting_high,
    output logic      [NUM_INPUTS-1:0] comparator_on,
    // Analog mux
    output logic      [4:0]            analog_channel,
    output logic      [NUM_INPUTS-1:0] analog_sel_onehot,
    output logic      [1:0]            analog_current,
    output logic                       analog_pullup,
    // Status bits for the serial response
    output logic      [NUM_INPUTS-1:0] status_bits,
    // Register contents
    output logic      [NUM_INPUTS-1:0] wetting_timer_enable,
    output logic      [NUM_INPUTS-1:0] input_high_impedance,
    output logic      [6:0]            analog_channel_select
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sclk_sync_q;
    logic [2:0] cs_sync_q;
    logic [1:0] mosi_sync_q;
    logic [NUM_INPUTS-1:0] cmp_meta_q;
    logic [NUM_INPUTS-1:0] cmp_q;
    logic [NUM_INPUTS-1:0] cmp_prev_q;
    logic [NUM_INPUTS-1:0] sw_meta_q;
    logic [NUM_INPUTS-1:0] sw_q;

    // Two flops per pin; third stage only for edge finding
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_sync_q <= 3'h0;
            cs_sync_q   <= 3'h7;
            mosi_sync_q <= 2'h0;
        end else if (clk_en) begin
            sclk_sync_q <= {sclk_sync_q[1:0], spi_sclk};
            cs_sync_q   <= {cs_sync_q[1:0], spi_cs_n};
            mosi_sync_q <= {mosi_sync_q[0], spi_mosi};
        end
    end

    // Comparators are asynchronous to our clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmp_meta_q <= '0;
            cmp_q      <= '0;
            cmp_prev_q <= '0;
            sw_meta_q  <= '0;
            sw_q       <= '0;
        end else if (clk_en) begin
            cmp_meta_q <= input_above_thresh;
            cmp_q      <= cmp_meta_q;
            cmp_prev_q <= cmp_q;
            sw_meta_q  <= switch_closed;
            sw_q       <= sw_meta_q;
        end
    end

    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic cs_low;
    assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
    assign cs_fall   = ~cs_sync_q[1] & cs_sync_q[2];
    assign cs_rise   = cs_sync_q[1] & ~cs_sync_q[2];
    assign cs_low    = ~cs_sync_q[1];

    // ------------------------------------------------------------
    // Frame shifter
    // ------------------------------------------------------------
    logic [FRAME_BITS-1:0] shift_q;
    logic [5:0]            bit_cnt_q;

    // MSB first; count saturates so long frames still end cleanly
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shift_q   <= '0;
            bit_cnt_q <= 6'h00;
        end else if (clk_en) begin
            if (cs_fall) begin
                bit_cnt_q <= 6'h00;
            end else if (cs_low && sclk_rise) begin
                shift_q <= {shift_q[FRAME_BITS-2:0], mosi_sync_q[1]};
                if (bit_cnt_q != 6'h3f) begin
                    bit_cnt_q <= bit_cnt_q + 6'h01;
                end
            end
        end
    end

    // A frame counts only with exactly 24 clocks and a live host side
    logic       frame_done;
    logic [7:0] cmd;
    assign frame_done = cs_rise && (bit_cnt_q == 6'(FRAME_BITS));
    assign cmd = shift_q[CMD_MSB:CMD_LSB];

    logic accept;
    assign accept = frame_done && normal_mode && logic_supply_ok;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] timer_en_q;
    logic [NUM_INPUTS-1:0] hiz_q;
    logic [6:0]            analog_q;

    // Ground inputs occupy bits 13..0, programmable bits 21..14
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer_en_q <= RST_TIMER_EN;
            hiz_q      <= RST_HIZ;
            analog_q   <= RST_ANALOG;
        end else if (clk_en && accept) begin
            case (cmd)
                CMD_TIMER_PROG: begin
                    timer_en_q[NUM_INPUTS-1:NUM_GND] <= shift_q[NUM_PROG-1:0];
                end
                CMD_TIMER_GND: begin
                    timer_en_q[NUM_GND-1:0] <= shift_q[NUM_GND-1:0];
                end
                CMD_HIZ_PROG: begin
                    hiz_q[NUM_INPUTS-1:NUM_GND] <= shift_q[NUM_PROG-1:0];
                end
                CMD_HIZ_GND: begin
                    hiz_q[NUM_GND-1:0] <= shift_q[NUM_GND-1:0];
                end
                CMD_ANALOG: begin
                    // Bits 15..7 dropped; channel and current land together
                    analog_q <= shift_q[CUR_MSB:CHAN_LSB];
                end
                CMD_RESET: begin
                    timer_en_q <= RST_TIMER_EN;
                    hiz_q      <= RST_HIZ;
                    analog_q   <= RST_ANALOG;
                end
                default: begin
                end
            endcase
        end
    end

    assign wetting_timer_enable  = timer_en_q;
    assign input_high_impedance  = hiz_q;
    assign analog_channel_select = analog_q;

    // ------------------------------------------------------------
    // Wetting timers, one per input
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] expired;

    generate
        for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_wet
            logic [31:0] cnt_q;
            logic        run_q;
            logic        exp_q;

            assign expired[i] = exp_q;

            // Restart on each threshold crossing; expiry holds until the next
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    cnt_q <= 32'h0;
                    run_q <= 1'b0;
                    exp_q <= 1'b0;
                end else if (clk_en) begin
                    if (cmp_q[i] != cmp_prev_q[i]) begin
                        cnt_q <= 32'h0;
                        run_q <= 1'b1;
                        exp_q <= 1'b0;
                    end else if (run_q) begin
                        if (cnt_q >= 32'(WET_COUNT - 1)) begin
                            run_q <= 1'b0;
                            exp_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q + 32'h1;
                        end
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Current drive
    // ------------------------------------------------------------
    // High current until an enabled timer expires; disabled holds high
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wetting_high  <= '1;
            input_hiz     <= RST_HIZ;
            comparator_on <= '1;
        end else if (clk_en) begin
            wetting_high  <= ~(expired & timer_en_q);
            input_hiz     <= hiz_q;
            comparator_on <= '1;
        end
    end

    // ------------------------------------------------------------
    // Analog mux decode
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] onehot_d;
    logic [1:0]            cur_d;

    // Codes past the last channel select nothing
    always_comb begin
        onehot_d = '0;
        if (analog_q[CHAN_MSB:CHAN_LSB] != CHAN_NONE &&
            analog_q[CHAN_MSB:CHAN_LSB] <= CHAN_LAST) begin
            onehot_d[analog_q[CHAN_MSB:CHAN_LSB] - CHAN_GND_BASE] = 1'b1;
        end
        cur_d = analog_q[CUR_MSB:CUR_LSB];
        if (cur_d == CUR_ILLEG) begin
            cur_d = CUR_HIZ;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            analog_channel    <= CHAN_NONE;
            analog_sel_onehot <= '0;
            analog_current    <= CUR_HIZ;
            analog_pullup     <= 1'b1;
        end else if (clk_en) begin
            analog_channel    <= analog_q[CHAN_MSB:CHAN_LSB];
            analog_sel_onehot <= onehot_d;
            analog_current    <= cur_d;
            analog_pullup     <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Status response
    // ------------------------------------------------------------
    // Latched at frame start; selected analog input forced low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_bits <= '0;
        end else if (clk_en && cs_fall) begin
            status_bits <= sw_q & ~onehot_d;
        end
    end

endmodule : switch_input_config_regs

// >>> verif/switch_input_config_regs_chk.sv
// Concurrent checks on the switch input configuration block ports
module switch_input_config_regs_chk
    import switch_cfg_pkg::*;
#(
    parameter int WET_COUNT = WET_CYCLES
) (
    // Clock, reset and pins
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  clk_en,
    input wire logic                  spi_cs_n,
    input wire logic [NUM_INPUTS-1:0] input_above_thresh,
    // Outputs under watch
    input wire logic [NUM_INPUTS-1:0] input_hiz,
    input wire logic [NUM_INPUTS-1:0] wetting_high,
    input wire logic [NUM_INPUTS-1:0] comparator_on,
    input wire logic [4:0]            analog_channel,
    input wire logic [NUM_INPUTS-1:0] analog_sel_onehot,
    input wire logic [1:0]            analog_current,
    input wire logic                  analog_pullup,
    input wire logic [NUM_INPUTS-1:0] status_bits,
    input wire logic [NUM_INPUTS-1:0] wetting_timer_enable,
    input wire logic [NUM_INPUTS-1:0] input_high_impedance,
    input wire logic [6:0]            analog_channel_select
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Input 0 timer age; disarmed when its enable moves
    // ------------------------------------------------------------
    logic [15:0] cnt_q;
    logic        armed_q, thr_q, en_q;
    always_ff @(posedge ref_clk) begin
        thr_q <= input_above_thresh[0];
        en_q  <= wetting_timer_enable[0];
        if (rst || en_q != wetting_timer_enable[0]) armed_q <= 1'b0;
        else if (thr_q != input_above_thresh[0]) armed_q <= 1'b1;
        if (rst || thr_q != input_above_thresh[0]) cnt_q <= 16'h0000;
        else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_pull; analog_pullup; endproperty
    property p_comp; comparator_on == '1; endproperty
    property p_hiz; input_hiz == $past(input_high_impedance); endproperty
    property p_cur; analog_current == (($past(analog_channel_select[6:5]) == CUR_ILLEG)
        ? CUR_HIZ : $past(analog_channel_select[6:5])); endproperty
    property p_chan; analog_sel_onehot == ((analog_channel inside {[1:22]})
        ? (NUM_INPUTS'(1) << (analog_channel - 5'h01)) : '0); endproperty
    property p_stat; $fell(spi_cs_n) |-> ##6 ((status_bits & analog_sel_onehot) == '0); endproperty
    property p_dis; clk_en && wetting_timer_enable != '1
        |=> (wetting_high | $past(wetting_timer_enable)) == '1; endproperty
    property p_start; armed_q && wetting_timer_enable[0] && cnt_q == WET_COUNT - 4
        |-> wetting_high[0]; endproperty
    property p_drop; armed_q && wetting_timer_enable[0] && cnt_q == WET_COUNT + 8
        |-> !wetting_high[0]; endproperty
    property p_rst; $fell(rst) |-> input_hiz == '1 && wetting_high == '1
        && wetting_timer_enable == '1 && analog_channel_select == 7'h00; endproperty
    property p_frame; $changed({wetting_timer_enable, input_high_impedance,
        analog_channel_select}) |-> $past(spi_cs_n) && $past(spi_cs_n, 2); endproperty
    a_pull: assert property (p_pull) else $error("pull-down on analog channel");
    a_comp: assert property (p_comp) else $error("comparator switched off");
    a_hiz: assert property (p_hiz) else $error("float not applied");
    a_cur: assert property (p_cur) else $error("current select wrong");
    a_chan: assert property (p_chan) else $error("channel decode wrong");
    a_stat: assert property (p_stat) else $error("selected input status set");
    a_dis: assert property (p_dis) else $error("disabled timer cut current");
    a_start: assert property (p_start) else $error("current cut early");
    a_drop: assert property (p_drop) else $error("current not cut");
    a_rst: assert property (p_rst) else $error("reset values wrong");
    a_frame: assert property (p_frame) else $error("write before frame end");
    c_last: cover property (analog_channel == CHAN_LAST);
    c_drop: cover property ($fell(wetting_high[0]));
    c_ill: cover property (analog_channel_select[6:5] == CUR_ILLEG);
endmodule : switch_input_config_regs_chk

bind switch_input_config_regs switch_input_config_regs_chk #(.WET_COUNT(WET_COUNT)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .spi_cs_n(spi_cs_n),
    .input_above_thresh(input_above_thresh), .input_hiz(input_hiz),
    .wetting_high(wetting_high), .comparator_on(comparator_on),
    .analog_channel(analog_channel), .analog_sel_onehot(analog_sel_onehot),
    .analog_current(analog_current), .analog_pullup(analog_pullup),
    .status_bits(status_bits), .wetting_timer_enable(wetting_timer_enable),
    .input_high_impedance(input_high_impedance),
    .analog_channel_select(analog_channel_select));

// >>> verif/spi_host_model.sv
// Host serial master model that sends command frames
module spi_host_model (
    // Serial pins toward the block
    output logic sclk,
    output logic cs_n,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clock stands low between frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Shift n bits MSB first, 160 ns per bit; data line scrambled after
    task automatic send(input logic [23:0] f, input int n);
        cs_n = 1'b0;
        #80;
        for (int i = 23; i > 23 - n; i--) begin
            mosi = f[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        mosi = ~mosi;
        #80 cs_n = 1'b1;
        #400;
    endtask : send
endmodule : spi_host_model

// >>> verif/switch_input_config_regs_tb.sv
// Self-checking bench for the switch input configuration block
module switch_input_config_regs_tb
    import switch_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [67:0] regs; logic [67:0] outs;} note_s;
    logic ref_clk = 1'b0, rst = 1'b1, nm = 1'b1, sup = 1'b1, sclk, cs_n, mosi;
    logic [21:0] thr = '0, sw = '0, ten = '1, hiz = '1;
    logic [21:0] hiz_o, wet_o, ten_o, hizr_o, oh_o, st_o;
    logic [6:0]  ana = '0, ana_o;
    logic [4:0]  ch_o;
    logic [1:0]  cur_o;
    int          bad_count = 0, check_count = 0, cyc = 0;
    note_s       notes[$];
    always #10 ref_clk = ~ref_clk;
    spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));
    switch_input_config_regs #(.WET_COUNT(50)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .normal_mode(nm),
        .logic_supply_ok(sup), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .input_above_thresh(thr), .switch_closed(sw), .input_hiz(hiz_o),
        .wetting_high(wet_o), .comparator_on(), .analog_channel(ch_o),
        .analog_sel_onehot(oh_o), .analog_current(cur_o), .analog_pullup(),
        .status_bits(st_o), .wetting_timer_enable(ten_o),
        .input_high_impedance(hizr_o), .analog_channel_select(ana_o));
    function automatic logic [21:0] f1h(input logic [4:0] c);
        return (c >= 5'h01 && c <= 5'h16) ? 22'h000001 << (c - 5'h01) : 22'h000000;
    endfunction : f1h
    task automatic chk(input logic [67:0] got, input logic [67:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Model the registers, note the outcome, then send the frame
    task automatic cmd(input logic [7:0] c, input logic [15:0] d, input int n);
        note_s e;
        e.outs[21:0] = sw & ~f1h(ana[4:0]);
        if (n == 24 && nm && sup) begin
            case (c)
                CMD_TIMER_PROG: ten[21:14] = d[7:0];
                CMD_TIMER_GND:  ten[13:0] = d[13:0];
                CMD_HIZ_PROG:   hiz[21:14] = d[7:0];
                CMD_HIZ_GND:    hiz[13:0] = d[13:0];
                CMD_ANALOG:     ana = d[6:0];
                CMD_RESET: begin
                    ten = '1;
                    hiz = '1;
                    ana = '0;
                end
                default: ;
            endcase
        end
        e.regs = 68'({ten, hiz, ana});
        e.outs[67:22] = {hiz, (ana[6:5] == 2'h3) ? 2'h0 : ana[6:5], f1h(ana[4:0])};
        notes.push_back(e);
        u_host.send({c, d}, n);
    endtask : cmd
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    // Compare settled outputs with the oldest note after each frame
    // The pin settling high at time zero is not a frame end
    always @(posedge cs_n) begin
        note_s e;
        if (!rst) begin
            repeat (8) @(negedge ref_clk);
            if (notes.size() != 0) begin
                e = notes.pop_front();
                chk(68'({ten_o, hizr_o, ana_o}), e.regs);
                chk({hiz_o, cur_o, oh_o, st_o}, e.outs);
            end else begin
                bad_count++;
                $display("ERROR at %0t: frame ended with no expected note", $time);
            end
        end
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("ERROR at %0t: run did not finish in time", $time);
            close_out();
        end
    end
    initial begin
        logic [7:0] codes[4] = '{CMD_TIMER_PROG, CMD_TIMER_GND, CMD_HIZ_PROG, CMD_HIZ_GND};
        void'($urandom(95317));
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        cmd(8'h00, 16'hffff, 24);
        for (int k = 0; k < 8; k++) cmd(codes[k % 4], 16'($urandom), 24);
        $display("register write test done");
        for (int c = 0; c < 24; c++) begin
            @(negedge ref_clk) sw = 22'($urandom);
            cmd(CMD_ANALOG, {9'($urandom), 2'(c), 5'(c)}, 24);
        end
        cmd(8'h00, 16'h0000, 24);
        $display("analog select test done");
        cmd(CMD_ANALOG, 16'h0045, 23);
        @(negedge ref_clk) nm = 1'b0;
        cmd(CMD_HIZ_GND, 16'h0000, 24);
        @(negedge ref_clk) {nm, sup} = 2'b10;
        cmd(CMD_HIZ_PROG, 16'h0000, 24);
        @(negedge ref_clk) sup = 1'b1;
        cmd(8'h0b, 16'h00ff, 24);
        cmd(CMD_RESET, 16'h1234, 24);
        $display("refusal and reset test done");
        cmd(CMD_TIMER_GND, 16'h0001, 24);
        @(negedge ref_clk) thr = ~thr;
        repeat (30) @(negedge ref_clk);
        chk(68'(wet_o[0]), 68'h1);
        repeat (40) @(negedge ref_clk);
        chk(68'(wet_o[0]), 68'h0);
        cmd(CMD_TIMER_GND, 16'h0000, 24);
        chk(68'(wet_o[0]), 68'h1);
        $display("wetting timer test done");
        repeat (20) @(negedge ref_clk);
        close_out();
    end
endmodule : switch_input_config_regs_tb
